/* File: rtl/ppm_pkg.sv */
// Constants and types shared by the port pin function multiplexer
package ppm_pkg;

  // ****************************************
  // System configuration bit positions
  // ****************************************
  localparam int unsigned SYS_HOST_MODE_BIT = 1;
  localparam int unsigned SYS_CHANB_BIT = 2;
  localparam int unsigned SYS_PORTB_LOW_BIT = 5;
  localparam int unsigned SYS_PORTB_HIGH_BIT = 6;
  localparam int unsigned SYS_PORTC_BIT = 7;

  // ****************************************
  // Interrupt-edge/pin-mux bit positions
  // ****************************************
  localparam int unsigned PMX_DAISY_BIT = 2;
  localparam int unsigned PMX_MEMSTRB_BIT = 3;

  // ****************************************
  // Reset values and pin slices
  // ****************************************
  localparam logic [7:0] SYS_CFG_RESET = 8'h00;
  localparam logic [7:0] PIN_MUX_RESET = 8'h00;
  localparam int unsigned PB_HIGH_LSB = 5;
  localparam int unsigned PB_CTS_IDX = 1;
  localparam int unsigned PC_SHARED_IDX = 2;
  localparam logic IDLE_LEVEL = 1'h1;

  // One pin or one function's drive: level and active-low enable
  typedef struct packed {
    logic out;
    logic oenN;
  } ppm_pad_t;

  // Triple-function pin owner
  typedef enum logic [1:0] {
    TRI_CPU,
    TRI_CHANB,
    TRI_HOST
  } ppm_tri_t;

  // All configuration register state
  typedef struct packed {
    logic [7:0] sysCfg;
    logic [7:0] pinMux;
  } ppm_state_t;

endpackage

/* File: rtl/ppm_port_pin_mux.sv */
// Pin function multiplexer for parallel ports and peripheral signal sets
`timescale 1ns/1ps

module ppm_port_pin_mux (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sysCfgWrite,
  input wire logic [7:0] sysCfgData,
  output logic [7:0] sysCfgRead,
  input wire logic pinMuxWrite,
  input wire logic [7:0] pinMuxData,
  output logic [7:0] pinMuxRead,
  input wire logic [7:0] pbPinIn,
  output ppm_pkg::ppm_pad_t [7:0] pbPinDrv,
  input ppm_pkg::ppm_pad_t [7:0] portBDrv,
  output logic [7:0] portBRead,
  input ppm_pkg::ppm_pad_t [7:0] periBDrv,
  output logic [7:0] periBIn,
  input wire logic [5:0] pcPinIn,
  output ppm_pkg::ppm_pad_t [5:0] pcPinDrv,
  input ppm_pkg::ppm_pad_t [5:0] portCDrv,
  output logic [7:0] portCRead,
  input wire logic extIntTwoN,
  input wire logic extIntOneN,
  input ppm_pkg::ppm_pad_t [5:0] chanADrv,
  output logic [5:0] chanAIn,
  input wire logic memWriteStrobeN,
  input wire logic [7:0] paPinIn,
  output ppm_pkg::ppm_pad_t [7:0] paPinDrv,
  input ppm_pkg::ppm_pad_t [7:0] portADrv,
  output logic [7:0] portARead,
  input ppm_pkg::ppm_pad_t [7:0] hostDataDrv,
  output logic [7:0] hostDataIn,
  input wire logic [6:0] cbPinIn,
  output ppm_pkg::ppm_pad_t [6:0] cbPinDrv,
  input ppm_pkg::ppm_pad_t [6:0] chanBDrv,
  output logic [6:0] chanBIn,
  input ppm_pkg::ppm_pad_t [6:0] hostCtlDrv,
  output logic [6:0] hostCtlIn,
  input wire logic [2:0] triPinIn,
  output ppm_pkg::ppm_pad_t [2:0] triPinDrv,
  input ppm_pkg::ppm_pad_t [2:0] cpuTriDrv,
  output logic [2:0] cpuTriIn,
  input ppm_pkg::ppm_pad_t [2:0] chanBTriDrv,
  output logic [2:0] chanBTriIn,
  input ppm_pkg::ppm_pad_t [2:0] hostTriDrv,
  output logic [2:0] hostTriIn,
  input wire logic auxIoChipSelN,
  input wire logic daisyChainEnOut,
  output logic csIeoPin,
  input wire logic memReadStrobeN,
  input wire logic memRequestN,
  output logic memStrobePin
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rstMeta_r;
  logic rstN;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_r <= 1'h0;
      rstN <= 1'h0;
    end
    else
    begin
      rstMeta_r <= 1'h1;
      rstN <= rstMeta_r;
    end
  end

  // ****************************************
  // Configuration state
  // ****************************************
  ppm_pkg::ppm_state_t state_r;
  ppm_pkg::ppm_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (sysCfgWrite)
    begin
      state_nxt.sysCfg = sysCfgData;
    end
    if (pinMuxWrite)
    begin
      state_nxt.pinMux = pinMuxData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r.sysCfg <= ppm_pkg::SYS_CFG_RESET;
      state_r.pinMux <= ppm_pkg::PIN_MUX_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign sysCfgRead = state_r.sysCfg;
  assign pinMuxRead = state_r.pinMux;

  // ****************************************
  // Decode
  // ****************************************
  // Bits 1,2: 00/10 CPU, 01 channel B, 11 host
  function automatic ppm_pkg::ppm_tri_t triOwner(input logic [7:0] cfg);
    if (cfg[ppm_pkg::SYS_CHANB_BIT] && cfg[ppm_pkg::SYS_HOST_MODE_BIT])
      return ppm_pkg::TRI_HOST;
    else if (cfg[ppm_pkg::SYS_CHANB_BIT])
      return ppm_pkg::TRI_CHANB;
    else
      return ppm_pkg::TRI_CPU;
  endfunction

  logic hostMode;
  logic portBLow;
  logic portBHigh;
  logic portCMode;
  logic memStrbAlt;
  logic [7:0] portBSel;
  ppm_pkg::ppm_tri_t triSel;

  assign hostMode = state_r.sysCfg[ppm_pkg::SYS_HOST_MODE_BIT];
  assign portBLow = state_r.sysCfg[ppm_pkg::SYS_PORTB_LOW_BIT];
  assign portBHigh = state_r.sysCfg[ppm_pkg::SYS_PORTB_HIGH_BIT];
  assign portCMode = state_r.sysCfg[ppm_pkg::SYS_PORTC_BIT];
  assign memStrbAlt = state_r.pinMux[ppm_pkg::PMX_MEMSTRB_BIT];
  assign portBSel = {{3{portBHigh}}, {5{portBLow}}};
  assign triSel = triOwner(state_r.sysCfg);

  // ****************************************
  // Port B pins
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : gPortB
      assign pbPinDrv[gi] = portBSel[gi] ? portBDrv[gi] : periBDrv[gi];
      if (gi == ppm_pkg::PB_CTS_IDX)
      begin : gCts
        // Transmitter of async 0 stays enabled when its gate pin is lost
        assign periBIn[gi] = portBSel[gi] ? 1'h0 : pbPinIn[gi];
      end
      else
      begin : gOther
        assign periBIn[gi] = portBSel[gi] ? ppm_pkg::IDLE_LEVEL : pbPinIn[gi];
      end
    end
  endgenerate

  assign portBRead = pbPinIn;

  // ****************************************
  // Port C pins
  // ****************************************
  generate
    for (gi = 0; gi < 6; gi++)
    begin : gPortC
      if (gi == ppm_pkg::PC_SHARED_IDX)
      begin : gShared
        // Memory-write strobe owns the pin until pin-mux bit 3 is set
        // One continuous driver: the pad vector is a single packed variable
        assign pcPinDrv[gi] = !memStrbAlt
          ? ppm_pkg::ppm_pad_t'{out: memWriteStrobeN, oenN: 1'h0}
          : (portCMode ? portCDrv[gi] : chanADrv[gi]);
        assign chanAIn[gi] = (memStrbAlt && !portCMode) ? pcPinIn[gi] : ppm_pkg::IDLE_LEVEL;
      end
      else
      begin : gPlain
        assign pcPinDrv[gi] = portCMode ? portCDrv[gi] : chanADrv[gi];
        assign chanAIn[gi] = portCMode ? ppm_pkg::IDLE_LEVEL : pcPinIn[gi];
      end
    end
  endgenerate

  // Bits 7 and 6 have no pin of their own and nothing to drive
  assign portCRead = {extIntTwoN, extIntOneN, pcPinIn};

  // ****************************************
  // Port A and host data bus
  // ****************************************
  generate
    for (gi = 0; gi < 8; gi++)
    begin : gPortA
      assign paPinDrv[gi] = hostMode ? hostDataDrv[gi] : portADrv[gi];
      assign hostDataIn[gi] = hostMode ? paPinIn[gi] : ppm_pkg::IDLE_LEVEL;
    end
  endgenerate

  assign portARead = paPinIn;

  // ****************************************
  // Channel B and host control pins
  // ****************************************
  // Host strobes read as idle in mode 0 so no stray host cycles start
  generate
    for (gi = 0; gi < 7; gi++)
    begin : gHostCtl
      assign cbPinDrv[gi] = hostMode ? hostCtlDrv[gi] : chanBDrv[gi];
      assign hostCtlIn[gi] = hostMode ? cbPinIn[gi] : ppm_pkg::IDLE_LEVEL;
      assign chanBIn[gi] = hostMode ? ppm_pkg::IDLE_LEVEL : cbPinIn[gi];
    end
  endgenerate

  // ****************************************
  // Triple-function pins
  // ****************************************
  // One process for all three pins keeps each output to a single driver
  always_comb
  begin
    cpuTriIn = {3{ppm_pkg::IDLE_LEVEL}};
    chanBTriIn = {3{ppm_pkg::IDLE_LEVEL}};
    hostTriIn = {3{ppm_pkg::IDLE_LEVEL}};
    triPinDrv = cpuTriDrv;
    unique case (triSel)
      ppm_pkg::TRI_CPU:
      begin
        triPinDrv = cpuTriDrv;
        cpuTriIn = triPinIn;
      end
      ppm_pkg::TRI_CHANB:
      begin
        triPinDrv = chanBTriDrv;
        chanBTriIn = triPinIn;
      end
      ppm_pkg::TRI_HOST:
      begin
        triPinDrv = hostTriDrv;
        hostTriIn = triPinIn;
      end
      default:
      begin
        triPinDrv = cpuTriDrv;
      end
    endcase
  end

  // ****************************************
  // Output-only shared pins
  // ****************************************
  assign csIeoPin = state_r.pinMux[ppm_pkg::PMX_DAISY_BIT] ? daisyChainEnOut
                                                          : auxIoChipSelN;
  assign memStrobePin = memStrbAlt ? memRequestN : memReadStrobeN;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_release;
    $rose(rstN);
  endsequence

  property p_reset_defaults;
    @(posedge ref_clk) s_release |-> (csIeoPin == auxIoChipSelN)
      && (pbPinDrv == periBDrv) && (triSel == ppm_pkg::TRI_CPU) && !hostMode;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("pins not at peripheral defaults after reset");

  property p_portb_high;
    @(posedge ref_clk) disable iff (!rstN)
      portBHigh |-> pbPinDrv[7:5] == portBDrv[7:5];
  endproperty
  a_portb_high: assert property (p_portb_high)
    else $error("port B high pins not given to port");

  property p_portb_low;
    @(posedge ref_clk) disable iff (!rstN)
      !portBLow |-> (pbPinDrv[4:0] == periBDrv[4:0]) && (periBIn[4:0] == pbPinIn[4:0]);
  endproperty
  a_portb_low: assert property (p_portb_low)
    else $error("port B low pins not with async units");

  property p_cts_low;
    @(posedge ref_clk) disable iff (!rstN)
      (sysCfgWrite && sysCfgData[ppm_pkg::SYS_PORTB_LOW_BIT]) |=> !periBIn[1] [*2];
  endproperty
  a_cts_low: assert property (p_cts_low)
    else $error("async 0 clear-to-send not held low");

  property p_portc;
    @(posedge ref_clk) disable iff (!rstN)
      portCMode |-> {pcPinDrv[5:3], pcPinDrv[1:0]} == {portCDrv[5:3], portCDrv[1:0]};
  endproperty
  a_portc: assert property (p_portc)
    else $error("port C pins not given to port");

  property p_shared_pin;
    @(posedge ref_clk) disable iff (!rstN)
      memStrbAlt ? (pcPinDrv[2] == (portCMode ? portCDrv[2] : chanADrv[2]))
                 : (pcPinDrv[2].out == memWriteStrobeN && !pcPinDrv[2].oenN);
  endproperty
  a_shared_pin: assert property (p_shared_pin)
    else $error("shared memory-write pin misrouted");

  property p_int_levels;
    @(posedge ref_clk) disable iff (!rstN)
      portCRead[7:6] == {extIntTwoN, extIntOneN};
  endproperty
  a_int_levels: assert property (p_int_levels)
    else $error("port C bits 7 and 6 not interrupt levels");

  property p_host_mode;
    @(posedge ref_clk) disable iff (!rstN)
      (sysCfgWrite && sysCfgData[ppm_pkg::SYS_HOST_MODE_BIT] && !pinMuxWrite)
      |=> (paPinDrv == hostDataDrv) && (cbPinDrv == hostCtlDrv) && (chanBIn == 7'h7F);
  endproperty
  a_host_mode: assert property (p_host_mode)
    else $error("host emulation pins not selected");

  property p_triple;
    @(posedge ref_clk) disable iff (!rstN)
      sysCfgWrite |=> triPinDrv == (!$past(sysCfgData[2]) ? cpuTriDrv
        : ($past(sysCfgData[1]) ? hostTriDrv : chanBTriDrv));
  endproperty
  a_triple: assert property (p_triple)
    else $error("triple-function pins wrong owner");

  property p_shared_outs;
    @(posedge ref_clk) disable iff (!rstN)
      pinMuxWrite |=> (csIeoPin == ($past(pinMuxData[2]) ? daisyChainEnOut : auxIoChipSelN))
        && (memStrobePin == ($past(pinMuxData[3]) ? memRequestN : memReadStrobeN));
  endproperty
  a_shared_outs: assert property (p_shared_outs)
    else $error("output-only shared pins misrouted");

endmodule

/* File: test/ppm_pin_model.sv */
// Pin-side model: outside parties meet the mux drives at the package pins
`timescale 1ns/1ps
module ppm_pin_model #(
  parameter int W = 8
) (
  input wire ppm_pkg::ppm_pad_t [W-1:0] drv,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  // Released pins follow the outside party, never a stale mux level
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      pin[i] = drv[i].oenN ? ext[i] : drv[i].out;
    end
  end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
module tb;
  // ****
  // Signals
  // ****
  logic ref_clk = 1'h0, reset_n = 1'h0, sysCfgWrite = 1'h0, pinMuxWrite = 1'h0;
  logic [7:0] sysCfgData = 8'h00, pinMuxData = 8'h00, sysCfgRead, pinMuxRead;
  logic [7:0] pbPinIn, portBRead, periBIn, portCRead, paPinIn, portARead, hostDataIn;
  logic [5:0] pcPinIn, chanAIn;
  logic [6:0] cbPinIn, chanBIn, hostCtlIn;
  logic [2:0] triPinIn, cpuTriIn, chanBTriIn, hostTriIn;
  logic extIntTwoN = 1'h1, extIntOneN = 1'h1, memWriteStrobeN = 1'h1, auxIoChipSelN = 1'h1;
  logic daisyChainEnOut = 1'h0, memReadStrobeN = 1'h1, memRequestN = 1'h0;
  logic csIeoPin, memStrobePin;
  ppm_pkg::ppm_pad_t [7:0] pbPinDrv, paPinDrv;
  ppm_pkg::ppm_pad_t [7:0] portBDrv = 16'h5A3C, periBDrv = 16'hC3A5;
  ppm_pkg::ppm_pad_t [7:0] portADrv = 16'h9C63, hostDataDrv = 16'h36C9;
  ppm_pkg::ppm_pad_t [5:0] pcPinDrv, portCDrv = 12'hA5C, chanADrv = 12'h3A3;
  ppm_pkg::ppm_pad_t [6:0] cbPinDrv, chanBDrv = 14'h2B5A, hostCtlDrv = 14'h14A5;
  ppm_pkg::ppm_pad_t [2:0] triPinDrv, cpuTriDrv = 6'h1B, chanBTriDrv = 6'h26;
  ppm_pkg::ppm_pad_t [2:0] hostTriDrv = 6'h0D;
  logic [7:0] pbExt = 8'h96, paExt = 8'h4D;
  logic [5:0] pcExt = 6'h2D;
  logic [6:0] cbExt = 7'h59;
  logic [2:0] triExt = 3'h5;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  ppm_port_pin_mux dut (.ref_clk, .reset_n, .sysCfgWrite, .sysCfgData, .sysCfgRead,
    .pinMuxWrite, .pinMuxData, .pinMuxRead, .pbPinIn, .pbPinDrv, .portBDrv, .portBRead,
    .periBDrv, .periBIn, .pcPinIn, .pcPinDrv, .portCDrv, .portCRead, .extIntTwoN,
    .extIntOneN, .chanADrv, .chanAIn, .memWriteStrobeN, .paPinIn, .paPinDrv, .portADrv,
    .portARead, .hostDataDrv, .hostDataIn, .cbPinIn, .cbPinDrv, .chanBDrv, .chanBIn,
    .hostCtlDrv, .hostCtlIn, .triPinIn, .triPinDrv, .cpuTriDrv, .cpuTriIn, .chanBTriDrv,
    .chanBTriIn, .hostTriDrv, .hostTriIn, .auxIoChipSelN, .daisyChainEnOut, .csIeoPin,
    .memReadStrobeN, .memRequestN, .memStrobePin);

  ppm_pin_model #(.W(8)) pbM (.drv(pbPinDrv), .ext(pbExt), .pin(pbPinIn));
  ppm_pin_model #(.W(6)) pcM (.drv(pcPinDrv), .ext(pcExt), .pin(pcPinIn));
  ppm_pin_model #(.W(8)) paM (.drv(paPinDrv), .ext(paExt), .pin(paPinIn));
  ppm_pin_model #(.W(7)) cbM (.drv(cbPinDrv), .ext(cbExt), .pin(cbPinIn));
  ppm_pin_model #(.W(3)) trM (.drv(triPinDrv), .ext(triExt), .pin(triPinIn));

  // ****
  // Helpers
  // ****
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Config write; returns once the new value is visible
  task automatic wr(input logic isPmx, input logic [7:0] v);
    @(posedge ref_clk);
    sysCfgWrite <= !isPmx;
    pinMuxWrite <= isPmx;
    sysCfgData <= v;
    pinMuxData <= v;
    @(posedge ref_clk);
    sysCfgWrite <= 1'h0;
    pinMuxWrite <= 1'h0;
    @(negedge ref_clk);
  endtask

  function automatic logic [15:0] mx(logic [7:0] sel, logic [15:0] a, logic [15:0] b);
    for (int i = 0; i < 8; i++)
    begin
      mx[2*i+:2] = sel[i] ? a[2*i+:2] : b[2*i+:2];
    end
  endfunction

  function automatic logic [7:0] lvl(logic [15:0] d, logic [7:0] x);
    for (int i = 0; i < 8; i++)
    begin
      lvl[i] = d[2*i] ? x[i] : d[2*i+1];
    end
  endfunction

  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    logic [15:0] e;
    logic [7:0] l, s, m;
    logic [5:0] g;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("sysCfgRead", sysCfgRead, 8'h00);
    chk("pinMuxRead", pinMuxRead, 8'h00);
    chk("csIeoPin", csIeoPin, auxIoChipSelN);
    for (int k = 0; k < 4; k++)
    begin
      s = 8'(k) << 5;
      wr(1'h0, s);
      m = {{3{s[6]}}, {5{s[5]}}};
      e = mx(m, portBDrv, periBDrv);
      l = lvl(e, pbExt);
      chk("sysCfgRead", sysCfgRead, s);
      chk("pbPinDrv", pbPinDrv, e);
      chk("portBRead", portBRead, l);
      chk("periBIn", periBIn, (l & ~m) | (m & 8'hFD));
    end
    for (int k = 0; k < 8; k++)
    begin
      @(posedge ref_clk);
      extIntTwoN <= k[0];
      extIntOneN <= !k[1];
      memWriteStrobeN <= k[2];
      auxIoChipSelN <= k[1];
      daisyChainEnOut <= !k[1];
      memReadStrobeN <= k[0];
      memRequestN <= !k[0];
      wr(1'h0, {k[0], 7'h00});
      wr(1'h1, {4'h0, k[1], k[2], 2'h0});
      e = mx({8{k[0]}}, {4'h0, portCDrv}, {4'h0, chanADrv});
      if (!k[1])
        e[5:4] = {memWriteStrobeN, 1'h0};
      g = ~({6{!k[0]}} & ~{3'h0, !k[1], 2'h0});
      l = lvl(e, {2'h0, pcExt});
      chk("pinMuxRead", pinMuxRead, {4'h0, k[1], k[2], 2'h0});
      chk("pcPinDrv", pcPinDrv, e[11:0]);
      chk("chanAIn", chanAIn, l[5:0] | g);
      chk("portCRead", portCRead, {extIntTwoN, extIntOneN, l[5:0]});
      chk("memStrobePin", memStrobePin, k[1] ? memRequestN : memReadStrobeN);
      chk("csIeoPin", csIeoPin, k[2] ? daisyChainEnOut : auxIoChipSelN);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(1'h0, {5'h00, k[1], k[0], 1'h0});
      e = mx({8{k[0]}}, hostDataDrv, portADrv);
      l = lvl(e, paExt);
      chk("paPinDrv", paPinDrv, e);
      chk("portARead", portARead, l);
      chk("hostDataIn", hostDataIn, k[0] ? l : 8'hFF);
      e = mx({8{k[0]}}, {2'h0, hostCtlDrv}, {2'h0, chanBDrv});
      l = lvl(e, {1'h0, cbExt});
      chk("cbPinDrv", cbPinDrv, e[13:0]);
      chk("chanBIn", chanBIn, k[0] ? 7'h7F : l[6:0]);
      chk("hostCtlIn", hostCtlIn, k[0] ? l[6:0] : 7'h7F);
      e = k[1] ? (k[0] ? hostTriDrv : chanBTriDrv) : cpuTriDrv;
      l = lvl(e, {5'h00, triExt});
      chk("triPinDrv", triPinDrv, e[5:0]);
      chk("cpuTriIn", cpuTriIn, k[1] ? 3'h7 : l[2:0]);
      chk("chanBTriIn", chanBTriIn, (k[1] && !k[0]) ? l[2:0] : 3'h7);
      chk("hostTriIn", hostTriIn, (k[1] && k[0]) ? l[2:0] : 3'h7);
    end
    // Reset in mid-run must clear the system configuration, hand port B to the peripherals and the memory strobe pin to the read strobe
    wr(1'h0, 8'hE6);
    @(posedge ref_clk);
    reset_n <= 1'h0;
    @(negedge ref_clk);
    chk("sysCfgRead", sysCfgRead, 8'h00);
    chk("pbPinDrv", pbPinDrv, periBDrv);
    chk("memStrobePin", memStrobePin, memReadStrobeN);
    @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("sysCfgRead", sysCfgRead, 8'h00);
    chk("csIeoPin", csIeoPin, auxIoChipSelN);
    wr(1'h1, 8'h0C);
    chk("pinMuxRead", pinMuxRead, 8'h0C);
    chk("csIeoPin", csIeoPin, daisyChainEnOut);
    results();
  end

  // Whole run needs well under 200 cycles
  initial
  begin
    #20000;
    n_mismatch++;
    results();
  end
endmodule
